/* rtl/dpc_check.sv */
/*
 Device permission check with permission cache, table fetch port and AXI4-Lite registers.
 Assumes the table walker answers each fetch with one descriptor pulse, the pipeline holds
 its request until taken, and AXI4-Lite masters follow the usual channel rules.
*/
`timescale 1ns/10ps
// Contract
// - Table use allowed only for EL1-regime streams; otherwise report bad stream entry.
// - Separate Non-secure and Realm tables, each enabled and looked up apart.
// - Lookup gives no access, access for specific identifiers, or access for any.
// - Streams with ATS off or split-stage need no table and pass unchecked.
// - Support for each security state is reported by its own identification flag.
// - No-access results deny the access and never enter the permission cache.
// - Addresses beyond the configured physical size are no access and fault.
// - Level 0 no-access entry or no-access level 1 field gives an access fault.
// - A write to a region with write permit clear faults.
// - Fully-coherent transactions treat the write permit bit as set.
// - Identifier match need follows policy and access control; Realm uses policy zero.
// - Required identifier mismatch against the stage 2 identifier faults.
// - A lookup fault takes priority and suppresses the access fault.
// - Non-secure table accesses always output to Non-secure space.
// - Realm table outputs Non-secure for control 01 or 10, else Realm.
// - Output space does not depend on the identifier match policy.
// - Write-only permission is treated as read and write.
// - Cache entries are indexed by security state, stream identifier and output address.
module dpc_check
   import dpc_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire dpc_req_t          req,
   output logic                   res_valid,
   input  wire logic              res_ready,
   output dpc_res_t               res,
   output logic                   fetch_valid,
   output logic [PA_W-1:0]        fetch_addr,
   output logic                   fetch_realm,
   input  wire logic              desc_valid,
   input  wire dpc_desc_t         desc,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic                   irq
);

   typedef struct packed {
      dpc_state_t              st;
      dpc_req_t                rq;
      dpc_desc_t               dsc;
      dpc_res_t                res;
      logic                    res_valid;
      logic                    fetch_valid;
      dpc_entry_t [CACHE_N-1:0] cache;
      logic [CACHE_IX_W-1:0]   victim;
      logic [2:0]              ctrl;
      logic [5:0]              ns_ps;
      logic [5:0]              rl_ps;
      logic [EV_W-1:0]         status;
      logic [EV_W-1:0]         enable;
      logic [15:0]             faults;
      logic                    aw_got;
      logic                    w_got;
      logic [ADDR_W-1:0]       awaddr;
      logic [DATA_W-1:0]       wdata;
      logic                    bvalid;
      logic                    rvalid;
      logic [DATA_W-1:0]       rdata;
      logic [1:0]              rresp;
      logic [1:0]              bresp;
   } dpc_regs_t;

   dpc_regs_t r;
   dpc_regs_t next_r;

   ////////////////////////////////////////////////////////////////////////////////////////////

   // Returns true when the address lies outside the configured physical size.
   function automatic logic out_of_range(input logic [PA_W-1:0] a, input logic [5:0] ps);
      logic [PA_W-1:0] lim;
      lim = '1;
      if (ps < 6'(PA_W)) begin
         lim = (PA_W'(1) << ps) - PA_W'(1);
      end
      return a > lim;
   endfunction : out_of_range

   // Returns true when the identifier must match for this policy and access control.
   function automatic logic vm_required(input logic [1:0] pol, input logic [1:0] ctl);
      logic req_m;
      req_m = 1'b0;
      case (pol)
         VM_POL_00: req_m = (ctl == ACCESS_CTL_00) || (ctl == ACCESS_CTL_01);
         VM_POL_01: req_m = (ctl == ACCESS_CTL_00);
         default:   req_m = 1'b0;
      endcase
      return req_m;
   endfunction : vm_required

   // Evaluates a descriptor against the held request.
   function automatic dpc_res_t evaluate(input dpc_req_t q, input dpc_desc_t d);
      dpc_res_t o;
      logic     wperm;
      logic     none;
      logic [1:0] pol;
      o = '0;
      wperm = d.w | q.coherent;
      none = d.level0_none || (d.acc == ACC_NONE);
      pol = q.realm ? VM_POL_00 : q.vm_policy;
      if (d.lookup_fault) begin
         o.lookup_fault = 1'b1;
      end else if (none) begin
         o.access_fault = 1'b1;
      end else if (q.write && !wperm) begin
         o.access_fault = 1'b1;
      end else if (vm_required(pol, d.access_control_field) &&
                   (d.virtual_machine_id != q.stage2_vm_identifier)) begin
         o.access_fault = 1'b1;
      end
      o.out_ns = !q.realm || (d.access_control_field == ACCESS_CTL_01) ||
                 (d.access_control_field == ACCESS_CTL_10);
      o.fwd = !o.access_fault && !o.lookup_fault;
      return o;
   endfunction : evaluate

   ////////////////////////////////////////////////////////////////////////////////////////////

   logic [CACHE_N-1:0] hit_vec;
   logic               hit;
   dpc_desc_t          hit_desc;

   genvar gi;
   generate
      for (gi = 0; gi < CACHE_N; gi++) begin : g_hit
         assign hit_vec[gi] = r.cache[gi].valid && (r.cache[gi].realm == r.rq.realm) &&
                              (r.cache[gi].sid == r.rq.sid) &&
                              (r.cache[gi].page == r.rq.addr[PA_W-1:GRAN_SHIFT]);
      end
   endgenerate

   always_comb begin
      hit_desc = '0;
      for (int i = 0; i < CACHE_N; i++) begin
         if (hit_vec[i]) begin
            hit_desc = r.cache[i].desc;
         end
      end
   end
   assign hit = |hit_vec;

   ////////////////////////////////////////////////////////////////////////////////////////////

   logic            tbl_en;
   logic            in_range_fault;
   logic [EV_W-1:0] ev;
   logic            do_write;
   logic            do_read;

   assign tbl_en = r.rq.realm ? (r.ctrl[CTRL_RL_EN] && RL_SUPPORT) :
                                (r.ctrl[CTRL_NS_EN] && NS_SUPPORT);
   assign in_range_fault = out_of_range(r.rq.addr, r.rq.realm ? r.rl_ps : r.ns_ps);
   assign do_write = r.aw_got && r.w_got && !r.bvalid;
   assign do_read  = s_axi_arvalid && !r.rvalid;

   always_comb begin
      next_r = r;
      ev = '0;
      case (r.st)
         DPC_IDLE: begin
            if (req_valid) begin
               next_r.rq = req;
               next_r.st = DPC_LOOKUP;
            end
         end
         DPC_LOOKUP: begin
            next_r.res = '0;
            next_r.res.out_ns = !r.rq.realm;
            next_r.st = DPC_DONE;
            next_r.res_valid = 1'b1;
            if (!r.rq.use_table || (r.rq.ats_mode == ATS_OFF) ||
                (r.rq.ats_mode == ATS_SPLIT)) begin
               next_r.res.fwd = 1'b1;
            end else if (r.rq.regime != REG_EL1) begin
               next_r.res.bad_stream_entry_error = 1'b1;
               ev[EV_BAD_ENTRY] = 1'b1;
            end else if (!tbl_en) begin
               next_r.res.fwd = 1'b1;
            end else if (in_range_fault) begin
               next_r.res.access_fault = 1'b1;
               ev[EV_ACCESS_FAULT] = 1'b1;
            end else if (hit) begin
               next_r.res = evaluate(r.rq, hit_desc);
               ev[EV_ACCESS_FAULT] = next_r.res.access_fault;
            end else begin
               next_r.res_valid = 1'b0;
               next_r.fetch_valid = 1'b1;
               next_r.st = DPC_WAIT;
            end
         end
         DPC_WAIT: begin
            next_r.fetch_valid = 1'b0;
            if (desc_valid) begin
               next_r.dsc = desc;
               next_r.st = DPC_CHECK;
            end
         end
         DPC_CHECK: begin
            next_r.res = evaluate(r.rq, r.dsc);
            next_r.res_valid = 1'b1;
            next_r.st = DPC_DONE;
            ev[EV_ACCESS_FAULT] = next_r.res.access_fault;
            ev[EV_LOOKUP_FAULT] = next_r.res.lookup_fault;
            if (!r.dsc.lookup_fault && !r.dsc.level0_none && (r.dsc.acc != ACC_NONE)) begin
               next_r.cache[r.victim] = '{valid: 1'b1, realm: r.rq.realm, sid: r.rq.sid,
                                          page: r.rq.addr[PA_W-1:GRAN_SHIFT], desc: r.dsc};
               next_r.victim = r.victim + CACHE_IX_W'(1);
            end
         end
         DPC_DONE: begin
            if (res_ready) begin
               next_r.res_valid = 1'b0;
               next_r.st = DPC_IDLE;
            end
         end
         default: begin
            next_r.st = DPC_IDLE;
         end
      endcase

      if (s_axi_awvalid && !r.aw_got) begin
         next_r.aw_got = 1'b1;
         next_r.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !r.w_got) begin
         next_r.w_got = 1'b1;
         next_r.wdata = s_axi_wdata;
      end
      next_r.ctrl[CTRL_FLUSH] = 1'b0;
      if (do_write) begin
         next_r.aw_got = 1'b0;
         next_r.w_got = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp = 2'h0;
         case (r.awaddr)
            OFF_CTRL:   next_r.ctrl = r.wdata[2:0];
            OFF_NS_PS:  next_r.ns_ps = r.wdata[5:0];
            OFF_RL_PS:  next_r.rl_ps = r.wdata[5:0];
            OFF_ENABLE: next_r.enable = r.wdata[EV_W-1:0];
            OFF_CLEAR:  next_r.status = r.status & ~r.wdata[EV_W-1:0];
            OFF_ID, OFF_STATUS, OFF_COUNT: next_r.bresp = 2'h0;
            default:    next_r.bresp = 2'h2;
         endcase
      end
      if (next_r.ctrl[CTRL_FLUSH]) begin
         for (int i = 0; i < CACHE_N; i++) begin
            next_r.cache[i].valid = 1'b0;
         end
      end
      next_r.status = next_r.status | ev;
      if (ev[EV_ACCESS_FAULT] && (r.faults != 16'hFFFF)) begin
         next_r.faults = r.faults + 16'h0001;
      end
      if (r.bvalid && s_axi_bready) begin
         next_r.bvalid = 1'b0;
      end

      if (do_read) begin
         next_r.rvalid = 1'b1;
         next_r.rresp = 2'h0;
         next_r.rdata = '0;
         case (s_axi_araddr)
            OFF_ID: begin
               next_r.rdata[ID_NS_SUP] = NS_SUPPORT;
               next_r.rdata[ID_RL_SUP] = RL_SUPPORT;
            end
            OFF_CTRL:   next_r.rdata[2:0] = r.ctrl;
            OFF_NS_PS:  next_r.rdata[5:0] = r.ns_ps;
            OFF_RL_PS:  next_r.rdata[5:0] = r.rl_ps;
            OFF_STATUS: next_r.rdata[EV_W-1:0] = r.status;
            OFF_ENABLE: next_r.rdata[EV_W-1:0] = r.enable;
            OFF_CLEAR:  next_r.rdata = '0;
            OFF_COUNT:  next_r.rdata[15:0] = r.faults;
            default:    next_r.rresp = 2'h2;
         endcase
      end else if (r.rvalid && s_axi_rready) begin
         next_r.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r       <= '0;
         r.st    <= DPC_IDLE;
         r.ns_ps <= PS_RESET;
         r.rl_ps <= PS_RESET;
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////

   assign req_ready     = (r.st == DPC_IDLE);
   assign res_valid     = r.res_valid;
   assign res           = r.res;
   assign fetch_valid   = r.fetch_valid;
   assign fetch_addr    = r.rq.addr;
   assign fetch_realm   = r.rq.realm;
   assign s_axi_awready = !r.aw_got;
   assign s_axi_wready  = !r.w_got;
   assign s_axi_bvalid  = r.bvalid;
   assign s_axi_bresp   = r.bresp;
   assign s_axi_arready = !r.rvalid;
   assign s_axi_rvalid  = r.rvalid;
   assign s_axi_rdata   = r.rdata;
   assign s_axi_rresp   = r.rresp;
   assign irq           = |(r.status & r.enable);

endmodule : dpc_check

/* rtl/dpc_pkg.sv */
/*
 Package for the device permission check: field widths, encodings, status and carrier structs.
 Assumes a single 20 MHz unit clock and a synchronous active-low reset.
*/
package dpc_pkg;

   localparam int           PA_W          = 48;
   localparam int           VIRTUAL_MACHINE_ID_W        = 16;
   localparam int           SID_W         = 32;
   localparam int           DATA_W        = 32;
   localparam int           ADDR_W        = 8;
   localparam int           CACHE_N       = 4;
   localparam int           CACHE_IX_W    = 2;
   localparam int           GRAN_SHIFT    = 12;

   localparam logic [ADDR_W-1:0] OFF_ID      = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_CTRL    = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_NS_PS   = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_RL_PS   = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_ENABLE  = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_CLEAR   = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_COUNT   = 8'h1C;

   localparam int CTRL_NS_EN  = 0;
   localparam int CTRL_RL_EN  = 1;
   localparam int CTRL_FLUSH  = 2;
   localparam int ID_NS_SUP   = 0;
   localparam int ID_RL_SUP   = 1;
   localparam logic NS_SUPPORT = 1'b1;
   localparam logic RL_SUPPORT = 1'b1;

   localparam int EV_ACCESS_FAULT = 0;
   localparam int EV_LOOKUP_FAULT = 1;
   localparam int EV_BAD_ENTRY    = 2;
   localparam int EV_W            = 3;

   localparam logic [1:0] VM_POL_00 = 2'h0;
   localparam logic [1:0] VM_POL_01 = 2'h1;
   localparam logic [1:0] VM_POL_10 = 2'h2;
   localparam logic [1:0] ACCESS_CTL_00 = 2'h0;
   localparam logic [1:0] ACCESS_CTL_01 = 2'h1;
   localparam logic [1:0] ACCESS_CTL_10 = 2'h2;
   localparam logic [1:0] ACC_NONE  = 2'h0;
   localparam logic [1:0] ATS_OFF   = 2'h0;
   localparam logic [1:0] ATS_SPLIT = 2'h2;
   localparam logic [1:0] REG_EL1   = 2'h1;
   localparam logic [5:0] PS_RESET  = 6'h30;

   typedef enum logic [4:0] {
      DPC_IDLE   = 5'b00001,
      DPC_LOOKUP = 5'b00010,
      DPC_WAIT   = 5'b00100,
      DPC_CHECK  = 5'b01000,
      DPC_DONE   = 5'b10000
   } dpc_state_t;

   typedef struct packed {
      logic [PA_W-1:0]   addr;
      logic [SID_W-1:0]  sid;
      logic              realm;
      logic              write;
      logic              coherent;
      logic              use_table;
      logic [1:0]        regime;
      logic [1:0]        ats_mode;
      logic [1:0]        vm_policy;
      logic [VIRTUAL_MACHINE_ID_W-1:0] stage2_vm_identifier;
   } dpc_req_t;

   typedef struct packed {
      logic              lookup_fault;
      logic              level0_none;
      logic [1:0]        acc;
      logic              w;
      logic [1:0]        access_control_field;
      logic [VIRTUAL_MACHINE_ID_W-1:0] virtual_machine_id;
   } dpc_desc_t;

   typedef struct packed {
      logic              valid;
      logic              realm;
      logic [SID_W-1:0]  sid;
      logic [PA_W-GRAN_SHIFT-1:0] page;
      dpc_desc_t         desc;
   } dpc_entry_t;

   typedef struct packed {
      logic              fwd;
      logic              access_fault;
      logic              lookup_fault;
      logic              bad_stream_entry_error;
      logic              out_ns;
   } dpc_res_t;

endpackage : dpc_pkg

/* verification/dpc_check_chk.sv */
/*
 Checker for dpc_check: request, fetch and result relations.
 Assumes it is bound to dpc_check and sees only that module's ports.
*/
`timescale 1ns/10ps
module dpc_check_chk
   import dpc_pkg::*;
(
   input wire logic            aclk,
   input wire logic            aresetn,
   input wire logic            req_valid,
   input wire logic            req_ready,
   input wire dpc_req_t        req,
   input wire logic            res_valid,
   input wire logic            res_ready,
   input wire dpc_res_t        res,
   input wire logic            fetch_valid,
   input wire logic [PA_W-1:0] fetch_addr,
   input wire logic            fetch_realm,
   input wire logic            desc_valid,
   input wire dpc_desc_t       desc
);
   logic            take;
   logic [PA_W-1:0] addr_q;
   logic            realm_q;

   assign take = req_valid && req_ready;

   // Holds the address and table select of the request in flight.
   always_ff @(posedge aclk) begin
      if (take) begin
         addr_q  <= req.addr;
         realm_q <= req.realm;
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   ////////////////////////////////////////////////////////////
   chk_fetch_pulse: assert property (fetch_valid |=> !fetch_valid)
      else $error("fetch request held longer than one cycle");
   chk_res_hold: assert property (res_valid && !res_ready |=> res_valid && $stable(res))
      else $error("result dropped or changed before it was taken");
   chk_answer_time: assert property (take |-> ##2 (res_valid || fetch_valid))
      else $error("no result and no fetch two cycles after a request");
   chk_bypass_fwd: assert property (take && !req.use_table |-> ##2 (res_valid && res.fwd))
      else $error("bypassed stream not forwarded");
   chk_bad_entry: assert property (take && req.use_table && req.ats_mode != ATS_OFF
      && req.ats_mode != ATS_SPLIT && req.regime != REG_EL1
      |-> ##2 (res_valid && res.bad_stream_entry_error && !res.fwd))
      else $error("non EL1 stream using the table not reported");
   chk_no_access: assert property (desc_valid && !desc.lookup_fault && desc.acc == ACC_NONE
      |-> ##2 (res_valid && res.access_fault && !res.fwd))
      else $error("no access descriptor did not fault");
   chk_lookup_first: assert property (res_valid && res.lookup_fault
      |-> !res.access_fault && !res.fwd)
      else $error("access fault raised beside a lookup fault");
   chk_fwd_clean: assert property (res_valid && res.fwd
      |-> !(res.access_fault || res.lookup_fault || res.bad_stream_entry_error))
      else $error("faulted access forwarded");
   chk_ns_space: assert property (res_valid && res.fwd && !realm_q |-> res.out_ns)
      else $error("non-secure table access left non-secure space");
   chk_fetch_addr: assert property (fetch_valid |-> fetch_addr == addr_q)
      else $error("fetch address differs from request address");
   chk_fetch_table: assert property (fetch_valid |-> fetch_realm == realm_q)
      else $error("fetch table select differs from request");

   cover property (fetch_valid);
   cover property (res_valid && res.bad_stream_entry_error);
   cover property (res_valid && res.access_fault);
endmodule : dpc_check_chk

bind dpc_check dpc_check_chk u_dpc_check_chk(.aclk, .aresetn, .req_valid, .req_ready, .req,
   .res_valid, .res_ready, .res, .fetch_valid, .fetch_addr, .fetch_realm, .desc_valid, .desc);

/* verification/dpc_check_test.sv */
/*
 Self-checking bench for dpc_check: decision table, then cache, irq, range and reset.
 Assumes the walker model answers every fetch.
*/
`timescale 1ns/10ps
module dpc_check_test
   import dpc_pkg::*;
;
   typedef struct packed {
      logic       r, wr, co, ut;
      logic [1:0] rg, at, po;
      logic       lf, l0;
      logic [1:0] acc;
      logic       w;
      logic [1:0] acf;
      logic       vm;
      logic [4:0] e;
   } dpc_row_t;

   logic              aclk, aresetn, req_valid, req_ready, res_valid, res_ready;
   logic              fetch_valid, fetch_realm, desc_valid, irq, s_axi_awvalid;
   logic              s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0]        s_axi_bresp, s_axi_rresp, rr;
   logic [3:0]        s_axi_wstrb;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, rd;
   logic [PA_W-1:0]   fetch_addr;
   dpc_req_t          req;
   dpc_res_t          res, got;
   dpc_desc_t         desc, tbl_desc;
   dpc_row_t          rows [18];
   int                fail_count = 0, total_checks = 0, cycles = 0, fetches = 0, lat = 0;
   int                f;

   dpc_check u_dpc_check(.aclk, .aresetn, .req_valid, .req_ready, .req, .res_valid,
      .res_ready, .res, .fetch_valid, .fetch_addr, .fetch_realm, .desc_valid, .desc,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .irq);
   dpc_walker_model u_dpc_walker_model(.aclk, .fetch_valid, .lat, .tbl_desc, .desc_valid,
      .desc);

   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   always @(posedge aclk) begin
      cycles++;
      if (fetch_valid) fetches++;
      if (cycles == 20000) begin
         fail_count++;
         report_and_stop();
      end
   end

   ////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rr = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : axi_rd

   // Builds a request and its descriptor from a row, then waits for the result.
   task automatic run_row(input int k, input logic [PA_W-1:0] a);
      dpc_row_t w;
      w = rows[k];
      tbl_desc  <= '{w.lf, w.l0, w.acc, w.w, w.acf, {15'h0003, !w.vm}};
      req       <= '{a, 32'h11, w.r, w.wr, w.co, w.ut, w.rg, w.at, w.po, 16'h0006};
      req_valid <= 1'b1;
      res_ready <= 1'b1;
      do @(posedge aclk); while (!req_ready);
      req_valid <= 1'b0;
      do @(posedge aclk); while (!res_valid);
      got = res;
      res_ready <= 1'b0;
      @(posedge aclk);
   endtask : run_row

   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask : do_reset

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : report_and_stop

   ////////////////////////////////////////////////////////////
   initial begin
      {aresetn, req_valid, res_ready, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      req = '0;
      tbl_desc = '0;
      s_axi_wstrb = 4'hF;
      rows = '{'{0,0,0,0,1,3,0,0,0,1,1,0,1,5'h11}, '{0,0,0,1,1,0,0,0,0,1,1,0,1,5'h11},
               '{0,0,0,1,1,2,0,0,0,1,1,0,1,5'h11}, '{0,0,0,1,2,3,0,0,0,1,1,0,1,5'h03},
               '{0,0,0,1,1,3,0,0,0,1,0,0,1,5'h11}, '{0,0,0,1,1,3,0,1,0,0,1,0,1,5'h05},
               '{0,0,0,1,1,3,0,0,1,1,1,0,1,5'h09}, '{0,0,0,1,1,3,0,0,0,0,1,0,1,5'h09},
               '{0,1,0,1,1,3,0,0,0,1,0,0,1,5'h09}, '{0,1,1,1,1,3,0,0,0,1,0,0,1,5'h11},
               '{0,0,0,1,1,3,0,0,0,1,1,1,0,5'h09}, '{0,0,0,1,1,3,0,0,0,1,1,2,0,5'h11},
               '{0,0,0,1,1,3,1,0,0,1,1,1,0,5'h11}, '{0,0,0,1,1,3,1,0,0,1,1,0,0,5'h09},
               '{0,0,0,1,1,3,2,0,0,1,1,0,0,5'h11}, '{1,0,0,1,1,3,2,0,0,1,1,0,0,5'h08},
               '{1,0,0,1,1,3,0,0,0,1,1,1,1,5'h11}, '{1,0,0,1,1,3,0,0,0,1,1,0,1,5'h10}};
      do_reset();
      axi_wr(OFF_CTRL, 32'h3);
      for (int i = 0; i < 18; i++) begin
         lat = (i % 2) * 4;
         run_row(i, 48'(i + 1) << GRAN_SHIFT);
         chk("result", {27'h0, rows[i].e}, {27'h0, got});
      end
      $display("test table done");
      f = fetches;
      run_row(14, 48'hF000);
      chk("cached fetch", f, fetches);
      chk("cached result", 32'h11, {27'h0, got});
      run_row(7, 48'h8000);
      chk("no access refetch", f + 1, fetches);
      axi_wr(OFF_CTRL, 32'h7);
      axi_rd(OFF_CTRL);
      chk("ctrl", 32'h3, rd);
      run_row(4, 48'h5000);
      chk("flushed fetch", f + 2, fetches);
      $display("test cache done");
      axi_wr(OFF_ENABLE, 32'h0);
      chk("irq masked", 32'h0, {31'h0, irq});
      axi_wr(OFF_ENABLE, 32'h1);
      chk("irq raised", 32'h1, {31'h0, irq});
      axi_rd(OFF_STATUS);
      chk("status", 32'h7, rd);
      axi_rd(OFF_COUNT);
      chk("fault count", 32'h7, rd);
      axi_wr(OFF_CLEAR, 32'h1);
      chk("irq cleared", 32'h0, {31'h0, irq});
      axi_rd(OFF_STATUS);
      chk("status cleared", 32'h6, rd);
      axi_rd(OFF_CLEAR);
      chk("clear reads", 32'h0, rd);
      $display("test irq done");
      axi_wr(OFF_NS_PS, 32'h20);
      f = fetches;
      run_row(4, 48'h1_0000_0000);
      chk("out of range", 32'h09, {27'h0, got});
      chk("range fetch", f, fetches);
      run_row(4, 48'h0_FFFF_F000);
      chk("range edge", 32'h11, {27'h0, got});
      axi_wr(OFF_CTRL, 32'h1);
      run_row(15, 48'h20000);
      chk("realm off", 32'h1, {31'h0, got.fwd});
      chk("realm off fetch", f + 1, fetches);
      axi_rd(8'h20);
      chk("unmapped read", 32'h2, {30'h0, rr});
      axi_wr(8'h24, 32'h1);
      chk("unmapped write", 32'h2, {30'h0, rr});
      $display("test range done");
      do_reset();
      axi_rd(OFF_ID);
      chk("id", 32'h3, rd);
      axi_rd(OFF_NS_PS);
      chk("ps reset", 32'h30, rd);
      axi_rd(OFF_CTRL);
      chk("ctrl reset", 32'h0, rd);
      axi_rd(OFF_STATUS);
      chk("status reset", 32'h0, rd);
      $display("test reset done");
      report_and_stop();
   end
endmodule : dpc_check_test

/* verification/dpc_walker_model.sv */
/*
 Table walker model: answers each fetch pulse with one descriptor pulse.
 Assumes the bench sets the descriptor and the latency before each request.
*/
`timescale 1ns/10ps
module dpc_walker_model
   import dpc_pkg::*;
(
   input  wire logic      aclk,
   input  wire logic      fetch_valid,
   input  wire logic [31:0] lat,
   input  wire dpc_desc_t tbl_desc,
   output logic           desc_valid,
   output dpc_desc_t      desc
);
   // Outside a pulse the descriptor shows the inverse of the last one, or zero before the first pulse.
   initial begin
      desc_valid = 1'b0;
      desc       = '0;
      forever begin
         @(posedge aclk);
         if (fetch_valid) begin
            repeat (lat) @(posedge aclk);
            desc_valid <= 1'b1;
            desc       <= tbl_desc;
            @(posedge aclk);
            desc_valid <= 1'b0;
            desc       <= ~tbl_desc;
         end
      end
   end
endmodule : dpc_walker_model
